// ===== test_two_wire_host_regs.sv
`timescale 1ns/1ns
// ****
// Register and clock bench
// ****
module test_two_wire_host_regs;
  logic                clk_sys_i = 1'b0;
  logic                reset_n_i = 1'b0;
  tw_pkg::tw_bus_req_t req = '0;
  logic [31:0]         rdata;
  logic                sda_oe;
  logic                scl_oe;
  logic                gcall = 1'b0;
  logic                pull;
  logic [31:0]         seed = 32'h50;
  int                  n_fail = 0;
  int                  n_checks = 0;
  wire                 sda = !(sda_oe || pull);
  logic [7:0]  ofs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'hE4, 8'hE8,
    8'h20, 8'h14};
  logic [31:0] wm [4] = '{32'h007F1300, 32'h007F0000, 32'h00FFFFFF,
    32'h0007FFFF};
  always #25 clk_sys_i = !clk_sys_i;
  tw_host_regs tw_host_regs_i (.clk_sys_i, .reset_n_i, .bus_req_i(req),
    .rdata_o(rdata), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .scl_o(),
    .scl_oe_o(scl_oe), .slave_busy_i(1'b0), .gen_call_i(gcall),
    .master_en_o(), .slave_en_o());
  tw_bus_slave tw_bus_slave_i (.clk_sys_i, .scl_i(!scl_oe), .sda_i(sda),
    .pull_o(pull));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int phase(int dv, int ex);
    return (dv << ex) + 4;
  endfunction
  task automatic finish_test();
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys_i) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys_i) req <= '0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    @(posedge clk_sys_i) req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys_i) req <= '0;
    #1 chk("rdata", e & m, rdata & m);
  endtask
  // A stuck clock pin must not hang the run.
  task automatic run(logic v, output int c);
    c = 0;
    while (scl_oe === v) begin
      @(posedge clk_sys_i) #1 c++;
      if (c > 300) begin
        n_fail++;
        finish_test();
      end
    end
  endtask
  initial begin
    logic [31:0] d;
    int          lo;
    int          hi;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ofs[i], ofs[i] == 8'h20);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(ofs[i], d);
      rd(ofs[i], d & wm[i]);
    end
    wr(8'h08, 32'h00120000);
    wr(8'h10, 32'h00010302);
    wr(8'hE4, 32'h1);
    wr(8'h10, rnd());
    rd(8'h10, 32'h00010302);
    rd(8'hE8, 32'h00001001);
    rd(8'hE8, 32'h0, 32'h1);
    wr(8'hE4, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h08, 32'h00340000);
    rd(8'h08, 32'h00120000);
    @(posedge clk_sys_i) gcall <= 1'b1;
    @(posedge clk_sys_i) gcall <= 1'b0;
    wr(8'h08, 32'h00340000);
    rd(8'h08, 32'h00340000);
    wr(8'h00, 32'h20);
    rd(8'h20, 32'h1, 32'h1);
    wr(8'h00, 32'h40);
    wr(8'h00, 32'h04);
    wr(8'h04, 32'h00500000);
    wr(8'h34, 32'hA5);
    run(1'b0, lo);
    run(1'b1, lo);
    run(1'b0, hi);
    chk("low", phase(2, 1), lo);
    chk("high", phase(3, 1), hi);
    wr(8'h00, 32'h02);
    repeat (900) @(posedge clk_sys_i);
    rd(8'h20, 32'h1, 32'h101);
    wr(8'h00, 32'h80);
    repeat (3) @(posedge clk_sys_i);
    rd(8'h04, 32'h0);
    finish_test();
  end
endmodule

// ===== tw_bus_slave.sv
`timescale 1ns/1ns
// ****
// Slave that acknowledges every byte
// ****
module tw_bus_slave (
  input  wire logic clk_sys_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      pull_o = 1'b0
);
  logic [3:0] falls = 4'h0;
  logic       scl_q = 1'b1;
  logic       sda_q = 1'b1;
  always @(posedge clk_sys_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      falls <= 4'h0;
    end else if (scl_q && !scl_i) begin
      falls <= (falls == 4'h9) ? 4'h1 : falls + 4'h1;
      pull_o <= falls == 4'h8;
    end
  end
endmodule

// ===== tw_host_regs.sv
// Our own choice: the strobed register port.
`timescale 1ns/1ns
// What this block does
// - Start command opens a frame with a start condition per master settings.
// - Master write begins a frame as soon as the transmit holding is written.
// - Stop command in master read issues stop after the current byte.
// - A not-acknowledge during master write, or of a read address, makes the device stop by itself.
// - Stop command in master write stops after the current data is sent.
// - Master enable bit turns master mode on; disable written zero alongside.
// - Master disable takes effect only after pending data has gone out.
// - Slave enable bit turns slave mode on; disable written zero alongside.
// - Slave disable takes effect after the slave finishes its character.
// - Quick command is sent only while master mode is enabled.
// - Soft reset acts as a system reset; zero command bits do nothing.
// - Address size field selects zero to three internal address bytes.
// - Direction bit selects write when zero and read when one.
// - Target device address is used only in master transfers.
// - Slave address and divider registers are locked while protect is set.
// - Own slave address changes only before slave enable or after a general call.
// - Internal address register supplies the internal address bytes.
// - Low phase lasts low divider shifted by exponent plus four cycles.
// - High phase lasts high divider shifted by exponent plus four cycles.
// - Divider settings drive the bus clock only in master mode.
// - Completed flag is set whenever the stop has been sent, even with holding still full.
// - Blocked writes set a violation flag and source; protect status read clears it.
module tw_host_regs (
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  input  wire tw_pkg::tw_bus_req_t bus_req_i,
  output logic [31:0]             rdata_o,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_o,
  output logic                    scl_o,
  output logic                    scl_oe_o,
  input  wire logic               slave_busy_i,
  input  wire logic               gen_call_i,
  output logic                    master_en_o,
  output logic                    slave_en_o
);

  typedef enum logic [2:0] {
    M_IDLE, M_START, M_BIT, M_ACK, M_HOLD, M_STOP
  } tw_mstate_t;

  // ***************************************************************
  // Soft reset and pin synchroniser
  // ***************************************************************
  // The soft reset comes from a flip-flop, so the combined reset has
  // no glitch; the flop itself is cleared only by the pin reset.
  logic       soft_rst;
  logic       core_rst_n;
  logic [2:0] sda_sync;
  logic       sda_f;
  logic       cmd_wr;

  assign cmd_wr = bus_req_i.wr && bus_req_i.addr == tw_pkg::OFS_CMD;
  assign core_rst_n = reset_n_i & ~soft_rst;

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= cmd_wr && bus_req_i.wdata[tw_pkg::CMD_SOFT_RESET_CMD];
    end
  end

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      sda_sync <= 3'h7;
      sda_f    <= 1'b1;
    end else begin
      sda_sync <= {sda_sync[1:0], sda_i};
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  logic [1:0]  internal_addr_value_sz;
  logic        dir;
  logic [6:0]  target_device_addr;
  logic [6:0]  own_slave_address;
  logic [23:0] internal_addr_value;
  logic [7:0]  low_phase_divider;
  logic [7:0]  high_phase_divider;
  logic [2:0]  divider_exponent;
  logic        write_protect_enable;
  logic        protect_violation_flag;
  logic [7:0]  wpsrc;
  logic        prot_hit;
  logic        prot_wr;
  logic        sr_rd;
  logic        wpsr_rd;
  logic        slave_en;
  logic        gacc;

  assign prot_hit = bus_req_i.addr == tw_pkg::OFS_SMR ||
                    bus_req_i.addr == tw_pkg::OFS_CWGR;
  assign prot_wr  = bus_req_i.wr && prot_hit && write_protect_enable;
  assign sr_rd    = bus_req_i.rd && bus_req_i.addr == tw_pkg::OFS_SR;
  assign wpsr_rd  = bus_req_i.rd && bus_req_i.addr == tw_pkg::OFS_WPSR;

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      internal_addr_value_sz <= 2'h0;
      dir     <= 1'b0;
      target_device_addr    <= 7'h00;
      own_slave_address    <= 7'h00;
      internal_addr_value    <= 24'h000000;
      low_phase_divider   <= 8'h00;
      high_phase_divider   <= 8'h00;
      divider_exponent   <= 3'h0;
      write_protect_enable    <= 1'b0;
    end else if (bus_req_i.wr) begin
      case (bus_req_i.addr)
        tw_pkg::OFS_MMR: begin
          internal_addr_value_sz <= bus_req_i.wdata[tw_pkg::MMR_SZ_LSB +: 2];
          dir     <= bus_req_i.wdata[tw_pkg::MMR_DIR];
          target_device_addr    <= bus_req_i.wdata[tw_pkg::MMR_DA_LSB +: 7];
        end
        tw_pkg::OFS_SMR: begin
          if (!write_protect_enable && (!slave_en || gacc)) begin
            own_slave_address <= bus_req_i.wdata[tw_pkg::SMR_SA_LSB +: 7];
          end
        end
        tw_pkg::OFS_INTERNAL_ADDR_VALUE: begin
          internal_addr_value <= bus_req_i.wdata[23:0];
        end
        tw_pkg::OFS_CWGR: begin
          if (!write_protect_enable) begin
            low_phase_divider <= bus_req_i.wdata[7:0];
            high_phase_divider <= bus_req_i.wdata[tw_pkg::CW_HI_LSB +: 8];
            divider_exponent <= bus_req_i.wdata[tw_pkg::CW_EXP_LSB +: 3];
          end
        end
        tw_pkg::OFS_WPMR: begin
          write_protect_enable <= bus_req_i.wdata[tw_pkg::WP_EN];
        end
        default: begin
        end
      endcase
    end
  end

  // A new violation in the same cycle as the clearing read survives.
  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      protect_violation_flag  <= 1'b0;
      wpsrc <= 8'h00;
    end else if (prot_wr) begin
      protect_violation_flag  <= 1'b1;
      wpsrc <= bus_req_i.addr;
    end else if (wpsr_rd) begin
      protect_violation_flag  <= 1'b0;
    end
  end

  // ***************************************************************
  // Command handling
  // ***************************************************************
  logic       master_en;
  logic       start_pend;
  logic       stop_pend;
  logic       quick_pend;
  logic       dis_pend;
  logic       sdis_pend;
  logic       thr_full;
  logic       ev_begin;
  logic       ev_done;
  tw_mstate_t state;

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      master_en  <= 1'b0;
      slave_en   <= 1'b0;
      start_pend <= 1'b0;
      stop_pend  <= 1'b0;
      quick_pend <= 1'b0;
      dis_pend   <= 1'b0;
      sdis_pend  <= 1'b0;
    end else begin
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_START]) begin
        start_pend <= 1'b1;
      end else if (ev_begin) begin
        start_pend <= 1'b0;
      end
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_STOP]) begin
        stop_pend <= 1'b1;
      end else if (ev_done) begin
        stop_pend <= 1'b0;
      end
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_QUICK] && master_en) begin
        quick_pend <= 1'b1;
      end else if (ev_begin) begin
        quick_pend <= 1'b0;
      end
      // Disable waits for an idle engine with nothing left to send.
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_MASTER_ENABLE_CMD] &&
          !bus_req_i.wdata[tw_pkg::CMD_MASTER_DISABLE_CMD]) begin
        master_en <= 1'b1;
      end else if (dis_pend && state == M_IDLE && !(thr_full && !dir)) begin
        master_en <= 1'b0;
        dis_pend  <= 1'b0;
      end
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_MASTER_DISABLE_CMD]) begin
        dis_pend <= 1'b1;
      end
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_SLAVE_ENABLE_CMD] &&
          !bus_req_i.wdata[tw_pkg::CMD_SLAVE_DISABLE_CMD]) begin
        slave_en <= 1'b1;
      end else if (sdis_pend && !slave_busy_i) begin
        slave_en  <= 1'b0;
        sdis_pend <= 1'b0;
      end
      if (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_SLAVE_DISABLE_CMD]) begin
        sdis_pend <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Master engine
  // ***************************************************************
  logic             half;
  logic [7:0]       shift;
  logic [2:0]       bit_cnt;
  tw_pkg::tw_role_t role;
  logic [1:0]       idx;
  logic             rs_done;
  logic             quick_act;
  logic [15:0]      tmr;
  tw_mstate_t       next_state;
  logic             next_half;
  logic [7:0]       next_shift;
  logic [2:0]       next_bit_cnt;
  tw_pkg::tw_role_t next_role;
  logic [1:0]       next_idx;
  logic             next_rs_done;
  logic             next_quick_act;
  logic             load_tmr;
  logic             phase_end;
  logic             rx_mode;
  logic             rw_bit;
  logic             ev_load;
  logic             ev_nack;
  logic             ev_rx;
  logic             halt;
  logic [7:0]       thr;
  logic [15:0]      low_len;
  logic [15:0]      high_len;

  assign low_len  = (16'(low_phase_divider) << divider_exponent) + tw_pkg::PHASE_EXTRA;
  assign high_len = (16'(high_phase_divider) << divider_exponent) + tw_pkg::PHASE_EXTRA;
  assign phase_end = tmr == 16'h0000;
  assign rx_mode   = role == tw_pkg::ROLE_DATA && dir;
  assign halt      = stop_pend || dis_pend;
  assign rw_bit    = (internal_addr_value_sz != 2'h0 && !rs_done && !quick_act) ? 1'b0 : dir;

  function automatic logic [7:0] internal_addr_value_byte(input logic [23:0] v,
                                           input logic [1:0]  n);
    internal_addr_value_byte = v[8 * n +: 8];
  endfunction

  always_comb begin
    next_state     = state;
    next_half      = half;
    next_shift     = shift;
    next_bit_cnt   = bit_cnt;
    next_role      = role;
    next_idx       = idx;
    next_rs_done   = rs_done;
    next_quick_act = quick_act;
    load_tmr       = 1'b0;
    ev_begin       = 1'b0;
    ev_done        = 1'b0;
    ev_load        = 1'b0;
    ev_nack        = 1'b0;
    ev_rx          = 1'b0;
    case (state)
      M_IDLE: begin
        // Dividers only come into use from here, with master mode on.
        if (master_en &&
            (start_pend || quick_pend || (!dir && thr_full))) begin
          next_state     = M_START;
          next_half      = 1'b0;
          load_tmr       = 1'b1;
          ev_begin       = 1'b1;
          next_rs_done   = 1'b0;
          next_quick_act = quick_pend;
        end
      end
      M_START: begin
        if (phase_end) begin
          load_tmr = 1'b1;
          if (!half) begin
            next_half = 1'b1;
          end else begin
            next_state   = M_BIT;
            next_half    = 1'b0;
            next_shift   = {target_device_addr, rw_bit};
            next_bit_cnt = tw_pkg::BIT_LAST;
            next_role    = tw_pkg::ROLE_ADDR;
          end
        end
      end
      M_BIT: begin
        if (phase_end) begin
          load_tmr = 1'b1;
          if (!half) begin
            next_half = 1'b1;
          end else begin
            next_half  = 1'b0;
            next_shift = {shift[6:0], rx_mode & sda_f};
            if (bit_cnt == 3'h0) begin
              next_state = M_ACK;
            end else begin
              next_bit_cnt = bit_cnt - 3'h1;
            end
          end
        end
      end
      M_ACK: begin
        if (phase_end) begin
          load_tmr = 1'b1;
          if (!half) begin
            next_half = 1'b1;
          end else begin
            next_half    = 1'b0;
            next_bit_cnt = tw_pkg::BIT_LAST;
            next_state   = M_BIT;
            if (!rx_mode && sda_f) begin
              ev_nack    = 1'b1;
              next_state = M_STOP;
            end else if (rx_mode) begin
              ev_rx = 1'b1;
              if (halt) begin
                next_state = M_STOP;
              end
            end else if (quick_act) begin
              next_state = M_STOP;
            end else if (role == tw_pkg::ROLE_ADDR && internal_addr_value_sz != 2'h0 &&
                         !rs_done) begin
              next_role  = tw_pkg::ROLE_INTERNAL_ADDR_VALUE;
              next_idx   = internal_addr_value_sz - 2'h1;
              next_shift = internal_addr_value_byte(internal_addr_value, internal_addr_value_sz - 2'h1);
            end else if (role == tw_pkg::ROLE_INTERNAL_ADDR_VALUE && idx != 2'h0) begin
              next_idx   = idx - 2'h1;
              next_shift = internal_addr_value_byte(internal_addr_value, idx - 2'h1);
            end else if (role == tw_pkg::ROLE_INTERNAL_ADDR_VALUE && dir) begin
              next_rs_done = 1'b1;
              next_state   = M_START;
            end else if (dir) begin
              next_role = tw_pkg::ROLE_DATA;
            end else begin
              next_state = M_HOLD;
            end
          end
        end
      end
      M_HOLD: begin
        // The clock is held low here while software has no data ready.
        if (stop_pend) begin
          // A byte still waiting in the holding register is dropped, so
          // the completed flag does not rise with that byte left behind.
          ev_load    = 1'b1;
          next_state = M_STOP;
          load_tmr   = 1'b1;
        end else if (thr_full) begin
          ev_load      = 1'b1;
          next_shift   = thr;
          next_role    = tw_pkg::ROLE_DATA;
          next_state   = M_BIT;
          next_bit_cnt = tw_pkg::BIT_LAST;
          load_tmr     = 1'b1;
        end else if (dis_pend) begin
          next_state = M_STOP;
          load_tmr   = 1'b1;
        end
      end
      M_STOP: begin
        if (phase_end) begin
          load_tmr = 1'b1;
          if (!half) begin
            next_half = 1'b1;
          end else begin
            next_half  = 1'b0;
            next_state = M_IDLE;
            ev_done    = 1'b1;
          end
        end
      end
      default: begin
        next_state = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      state     <= M_IDLE;
      half      <= 1'b0;
      shift     <= 8'h00;
      bit_cnt   <= 3'h0;
      role      <= tw_pkg::ROLE_ADDR;
      idx       <= 2'h0;
      rs_done   <= 1'b0;
      quick_act <= 1'b0;
      tmr       <= 16'h0000;
    end else begin
      state     <= next_state;
      half      <= next_half;
      shift     <= next_shift;
      bit_cnt   <= next_bit_cnt;
      role      <= next_role;
      idx       <= next_idx;
      rs_done   <= next_rs_done;
      quick_act <= next_quick_act;
      if (load_tmr) begin
        tmr <= (next_half ? high_len : low_len) - 16'h0001;
      end else if (!phase_end) begin
        tmr <= tmr - 16'h0001;
      end
    end
  end

  // Open-drain drive: enable high pulls the wire low.
  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_oe_o <= state == M_HOLD ||
                  ((state == M_BIT || state == M_ACK || state == M_STOP) &&
                   !half);
      case (state)
        M_START: sda_oe_o <= half;
        M_BIT:   sda_oe_o <= !rx_mode && !shift[7];
        M_ACK:   sda_oe_o <= rx_mode && !halt;
        M_STOP:  sda_oe_o <= 1'b1;
        default: sda_oe_o <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      master_en_o <= 1'b0;
      slave_en_o  <= 1'b0;
    end else begin
      scl_o       <= 1'b0;
      sda_o       <= 1'b0;
      master_en_o <= master_en;
      slave_en_o  <= slave_en;
    end
  end

  // ***************************************************************
  // Holding registers and status flags
  // ***************************************************************
  // Hardware events win over a clear in the same cycle throughout.
  logic       thr_wr;
  logic       rhr_rd;
  logic       transmission_completed;
  logic       txrdy;
  logic       rxrdy;
  logic       ovre;
  logic       nack;
  logic [7:0] rhr;

  assign thr_wr = bus_req_i.wr && bus_req_i.addr == tw_pkg::OFS_THR;
  assign rhr_rd = bus_req_i.rd && bus_req_i.addr == tw_pkg::OFS_RHR;

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      thr      <= 8'h00;
      thr_full <= 1'b0;
      rhr      <= 8'h00;
    end else begin
      if (thr_wr) begin
        thr      <= bus_req_i.wdata[7:0];
        thr_full <= 1'b1;
      end else if (ev_load) begin
        thr_full <= 1'b0;
      end
      if (ev_rx) begin
        rhr <= shift;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      transmission_completed <= tw_pkg::SR_RESET[tw_pkg::SR_TRANSMISSION_COMPLETED];
      txrdy  <= tw_pkg::SR_RESET[tw_pkg::SR_TXRDY];
      rxrdy  <= tw_pkg::SR_RESET[tw_pkg::SR_RXRDY];
      ovre   <= tw_pkg::SR_RESET[tw_pkg::SR_OVRE];
      nack   <= tw_pkg::SR_RESET[tw_pkg::SR_NACK];
      gacc   <= tw_pkg::SR_RESET[tw_pkg::SR_GACC];
    end else begin
      if (ev_done) begin
        transmission_completed <= 1'b1;
      end else if (ev_begin || thr_wr) begin
        transmission_completed <= 1'b0;
      end
      if (ev_load || ev_nack ||
          (cmd_wr && bus_req_i.wdata[tw_pkg::CMD_MASTER_ENABLE_CMD])) begin
        txrdy <= 1'b1;
      end else if (thr_wr) begin
        txrdy <= 1'b0;
      end
      if (ev_rx) begin
        rxrdy <= 1'b1;
      end else if (rhr_rd) begin
        rxrdy <= 1'b0;
      end
      if (ev_rx && rxrdy && !rhr_rd) begin
        ovre <= 1'b1;
      end else if (sr_rd) begin
        ovre <= 1'b0;
      end
      if (ev_nack) begin
        nack <= 1'b1;
      end else if (sr_rd) begin
        nack <= 1'b0;
      end
      if (gen_call_i) begin
        gacc <= 1'b1;
      end else if (sr_rd) begin
        gacc <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h00000000;
    case (bus_req_i.addr)
      tw_pkg::OFS_MMR: begin
        rd_val[tw_pkg::MMR_SZ_LSB +: 2] = internal_addr_value_sz;
        rd_val[tw_pkg::MMR_DIR]         = dir;
        rd_val[tw_pkg::MMR_DA_LSB +: 7] = target_device_addr;
      end
      tw_pkg::OFS_SMR:  rd_val[tw_pkg::SMR_SA_LSB +: 7] = own_slave_address;
      tw_pkg::OFS_INTERNAL_ADDR_VALUE: rd_val[23:0] = internal_addr_value;
      tw_pkg::OFS_CWGR: begin
        rd_val[7:0]                     = low_phase_divider;
        rd_val[tw_pkg::CW_HI_LSB +: 8]  = high_phase_divider;
        rd_val[tw_pkg::CW_EXP_LSB +: 3] = divider_exponent;
      end
      tw_pkg::OFS_SR: begin
        rd_val[tw_pkg::SR_TRANSMISSION_COMPLETED] = transmission_completed;
        rd_val[tw_pkg::SR_RXRDY]  = rxrdy;
        rd_val[tw_pkg::SR_TXRDY]  = txrdy;
        rd_val[tw_pkg::SR_GACC]   = gacc;
        rd_val[tw_pkg::SR_OVRE]   = ovre;
        rd_val[tw_pkg::SR_NACK]   = nack;
      end
      tw_pkg::OFS_RHR:  rd_val[7:0] = rhr;
      tw_pkg::OFS_WPMR: rd_val[tw_pkg::WP_EN] = write_protect_enable;
      tw_pkg::OFS_WPSR: begin
        rd_val[tw_pkg::WPS_FLAG]         = protect_violation_flag;
        rd_val[tw_pkg::WPS_SRC_LSB +: 8] = wpsrc;
      end
      default: rd_val = 32'h00000000;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i or negedge core_rst_n) begin
    if (!core_rst_n) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= bus_req_i.rd ? rd_val : 32'h00000000;
    end
  end

endmodule

// ===== tw_host_regs_props.sv
`timescale 1ns/1ns
// ****
// Port checks
// ****
module tw_host_regs_props (
  input wire logic                clk_sys_i,
  input wire logic                reset_n_i,
  input wire tw_pkg::tw_bus_req_t bus_req_i,
  input wire logic [31:0]         rdata_o,
  input wire logic                sda_oe_o,
  input wire logic                scl_oe_o,
  input wire logic                master_en_o,
  input wire logic                slave_en_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  wire [7:0]  a = bus_req_i.addr;
  wire [31:0] d = bus_req_i.wdata;
  wire        r = bus_req_i.rd;
  wire        cmd = bus_req_i.wr && a == 8'h00;
  sequence s_wps; r && a == 8'hE8; endsequence
  property p_men; cmd && d[7:2] == 6'h01 |-> ##2 master_en_o; endproperty
  a_men: assert property (p_men) else $error("no master");
  property p_sen; cmd && d[7:2] == 6'h04 |-> ##2 slave_en_o; endproperty
  a_sen: assert property (p_sen) else $error("no slave");
  property p_rst; cmd && d[7] |-> ##[1:4] !master_en_o && !slave_en_o;
  endproperty
  a_rst: assert property (p_rst) else $error("no soft reset");
  property p_quick; cmd && d == 32'h40 && !master_en_o |=> !scl_oe_o [*8];
  endproperty
  a_quick: assert property (p_quick) else $error("quick sent");
  property p_idle; !master_en_o [*3] |-> !scl_oe_o && !sda_oe_o; endproperty
  a_idle: assert property (p_idle) else $error("bus driven");
  property p_resv;
    r && a inside {8'h14, 8'h24, 8'h2C, 8'h34} |=> rdata_o == 32'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved data");
  property p_wpclr; s_wps ##1 !bus_req_i.wr ##1 s_wps |=> !rdata_o[0];
  endproperty
  a_wpclr: assert property (p_wpclr) else $error("flag kept");
  property p_stand; !$past(r) |-> rdata_o == 32'h0; endproperty
  a_stand: assert property (p_stand) else $error("stale data");
endmodule
bind tw_host_regs tw_host_regs_props props_i (.clk_sys_i, .reset_n_i,
  .bus_req_i, .rdata_o, .sda_oe_o, .scl_oe_o, .master_en_o, .slave_en_o);

// ===== tw_pkg.sv
package tw_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] OFS_CMD   = 8'h00;
  localparam logic [7:0] OFS_MMR   = 8'h04;
  localparam logic [7:0] OFS_SMR   = 8'h08;
  localparam logic [7:0] OFS_INTERNAL_ADDR_VALUE  = 8'h0C;
  localparam logic [7:0] OFS_CWGR  = 8'h10;
  localparam logic [7:0] OFS_SR    = 8'h20;
  localparam logic [7:0] OFS_IER   = 8'h24;
  localparam logic [7:0] OFS_IDR   = 8'h28;
  localparam logic [7:0] OFS_IMR   = 8'h2C;
  localparam logic [7:0] OFS_RHR   = 8'h30;
  localparam logic [7:0] OFS_THR   = 8'h34;
  localparam logic [7:0] OFS_WPMR  = 8'hE4;
  localparam logic [7:0] OFS_WPSR  = 8'hE8;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CMD_START   = 0;
  localparam int CMD_STOP    = 1;
  localparam int CMD_MASTER_ENABLE_CMD    = 2;
  localparam int CMD_MASTER_DISABLE_CMD   = 3;
  localparam int CMD_SLAVE_ENABLE_CMD    = 4;
  localparam int CMD_SLAVE_DISABLE_CMD   = 5;
  localparam int CMD_QUICK   = 6;
  localparam int CMD_SOFT_RESET_CMD   = 7;
  localparam int MMR_SZ_LSB  = 8;
  localparam int MMR_DIR     = 12;
  localparam int MMR_DA_LSB  = 16;
  localparam int SMR_SA_LSB  = 16;
  localparam int CW_HI_LSB   = 8;
  localparam int CW_EXP_LSB  = 16;
  localparam int SR_TRANSMISSION_COMPLETED   = 0;
  localparam int SR_RXRDY    = 1;
  localparam int SR_TXRDY    = 2;
  localparam int SR_GACC     = 5;
  localparam int SR_OVRE     = 6;
  localparam int SR_NACK     = 8;
  localparam int WP_EN       = 0;
  localparam int WPS_FLAG    = 0;
  localparam int WPS_SRC_LSB = 8;

  // ***************************************************************
  // Reset values and timing
  // ***************************************************************
  localparam logic [31:0] SR_RESET    = 32'h0000F009;
  localparam logic [15:0] PHASE_EXTRA = 16'h0004;
  localparam logic [2:0]  BIT_LAST    = 3'h7;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } tw_bus_req_t;

  typedef enum logic [1:0] {ROLE_ADDR, ROLE_INTERNAL_ADDR_VALUE, ROLE_DATA} tw_role_t;

endpackage
